// ===== dual_reload_down_timer.sv
/*
 two 32-bit reload down timers behind an ahb-lite slave, sharing one
 prescaled tick; each drives its own interrupt request line.
 assumes a single ahb-lite master on hclk with word transfers.
*/
`timescale 1ns/1ns
`include "timer_consts.svh"
module dual_reload_down_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic timer0_irq,
  output logic timer1_irq
);
  logic [7:0] prescale_ff;
  logic [1:0] run_en_ff;
  timer_pkg::word_t reload0_ff;
  timer_pkg::word_t reload1_ff;
  logic [15:0] wr_idx_ff;
  logic wr_pend_ff;
  logic [31:0] hrdata_ff;
  logic irq0_ff;
  logic irq1_ff;
  logic tick;
  logic [31:0] count0;
  logic [31:0] count1;
  logic uf0;
  logic uf1;
  logic addr_ok;
  logic [15:0] addr_idx;
  logic wr_now;
  logic cnt0_wr;
  logic cnt1_wr;
  logic [31:0] cnt0_wdata;
  logic [31:0] cnt1_wdata;
  logic [31:0] nxt_rdata;

  // ****************************************************************
  // ahb-lite address phase decode
  // ****************************************************************
  // word index from the byte address; the upper bits must be clear
  assign addr_idx = haddr[17:2];
  assign addr_ok = hsel && hready && htrans[1] && (haddr[31:18] == 14'h0);
  assign wr_now = ce && wr_pend_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 16'h0000;
    end else if (ce) begin
      if (hready) begin
        wr_pend_ff <= addr_ok && hwrite;
        wr_idx_ff <= addr_idx;
      end
    end
  end

  // zero-wait slave, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale_ff <= `PRESCALE_RESET;
      run_en_ff <= `RUN_EN_RESET;
      reload0_ff <= `WORD_RESET;
      reload1_ff <= `WORD_RESET;
    end else if (wr_now) begin
      case (wr_idx_ff)
        `IDX_PRESCALER: prescale_ff <= hwdata[7:0];
        `IDX_RUN_EN: run_en_ff <= hwdata[1:0];
        `IDX_T0_RELOAD_LO: begin
          reload0_ff[`HALF_LO_MSB:0] <= hwdata[15:0];
        end
        `IDX_T0_RELOAD_HI: begin
          reload0_ff[31:`HALF_HI_LSB] <= hwdata[15:0];
        end
        `IDX_T1_RELOAD_LO: begin
          reload1_ff[`HALF_LO_MSB:0] <= hwdata[15:0];
        end
        `IDX_T1_RELOAD_HI: begin
          reload1_ff[31:`HALF_HI_LSB] <= hwdata[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // count half writes merge with the live count
  // ****************************************************************
  // a half write keeps the other half of the live count as it is
  assign cnt0_wr = wr_pend_ff && ((wr_idx_ff == `IDX_T0_COUNT_LO) ||
    (wr_idx_ff == `IDX_T0_COUNT_HI));
  assign cnt1_wr = wr_pend_ff && ((wr_idx_ff == `IDX_T1_COUNT_LO) ||
    (wr_idx_ff == `IDX_T1_COUNT_HI));
  assign cnt0_wdata = (wr_idx_ff == `IDX_T0_COUNT_LO) ?
    {count0[31:16], hwdata[15:0]} : {hwdata[15:0], count0[15:0]};
  assign cnt1_wdata = (wr_idx_ff == `IDX_T1_COUNT_LO) ?
    {count1[31:16], hwdata[15:0]} : {hwdata[15:0], count1[15:0]};

  // ****************************************************************
  // tick and timers
  // ****************************************************************
  tick_prescaler u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .tick_prescale_value(prescale_ff),
    .tick(tick)
  );

  timer_channel u_t0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .run(run_en_ff[`FIRST_TIMER_RUN_BIT]),
    .tick(tick),
    .reload(reload0_ff),
    .count_wr(cnt0_wr),
    .count_wdata(cnt0_wdata),
    .count(count0),
    .underflow(uf0)
  );

  timer_channel u_t1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .run(run_en_ff[`SECOND_TIMER_RUN_BIT]),
    .tick(tick),
    .reload(reload1_ff),
    .count_wr(cnt1_wr),
    .count_wdata(cnt1_wdata),
    .count(count1),
    .underflow(uf1)
  );

  // one-cycle request pulse per underflow, registered for clean output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq0_ff <= 1'b0;
      irq1_ff <= 1'b0;
    end else if (ce) begin
      // held while ce is low, so a pulse stretches with the freeze
      irq0_ff <= uf0;
      irq1_ff <= uf1;
    end
  end
  assign timer0_irq = irq0_ff;
  assign timer1_irq = irq1_ff;

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (addr_idx)
      `IDX_PRESCALER: nxt_rdata = {24'h000000, prescale_ff};
      `IDX_RUN_EN: nxt_rdata = {30'h0, run_en_ff};
      `IDX_T0_RELOAD_LO: nxt_rdata = {16'h0000, reload0_ff[15:0]};
      `IDX_T0_RELOAD_HI: nxt_rdata = {16'h0000, reload0_ff[31:16]};
      `IDX_T0_COUNT_LO: nxt_rdata = {16'h0000, count0[15:0]};
      `IDX_T0_COUNT_HI: nxt_rdata = {16'h0000, count0[31:16]};
      `IDX_T1_RELOAD_LO: nxt_rdata = {16'h0000, reload1_ff[15:0]};
      `IDX_T1_RELOAD_HI: nxt_rdata = {16'h0000, reload1_ff[31:16]};
      `IDX_T1_COUNT_LO: nxt_rdata = {16'h0000, count1[15:0]};
      `IDX_T1_COUNT_HI: nxt_rdata = {16'h0000, count1[31:16]};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // live count sampled at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (ce && addr_ok && !hwrite) begin
      hrdata_ff <= nxt_rdata;
    end
  end
  assign hrdata = hrdata_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_tick_div;
    @(posedge hclk) disable iff (!hresetn)
    (ce && tick && prescale_ff == 8'h01)
      |=> (ce && !tick && prescale_ff == 8'h01)
      |=> (ce && prescale_ff == 8'h01) |-> tick;
  endproperty
  a_tick_div: assert property (p_tick_div)
    else $error("prescaled tick spacing wrong");

  property p_reload0;
    @(posedge hclk) disable iff (!hresetn)
    (ce && uf0 && !cnt0_wr && run_en_ff[0]) |=> (count0 == $past(reload0_ff));
  endproperty
  a_reload0: assert property (p_reload0)
    else $error("timer 0 did not reload after underflow");

  property p_dec0;
    @(posedge hclk) disable iff (!hresetn)
    (ce && tick && run_en_ff[0] && !cnt0_wr && count0 != 32'h0 &&
      $past(run_en_ff[0]) && $past(run_en_ff[0], 2))
      |=> (count0 == $past(count0) - 32'h1);
  endproperty
  a_dec0: assert property (p_dec0)
    else $error("timer 0 failed to decrement on tick");

  property p_irq_src;
    @(posedge hclk) disable iff (!hresetn)
    (timer0_irq && $past(ce))
      |-> $past(count0 == 32'h0 && run_en_ff[0] && tick);
  endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("timer 0 interrupt without underflow");

  property p_hold1;
    @(posedge hclk) disable iff (!hresetn)
    (!run_en_ff[1] && !cnt1_wr) |=> (count1 == $past(count1));
  endproperty
  a_hold1: assert property (p_hold1)
    else $error("disabled timer 1 changed its count");

  property p_noirq1;
    @(posedge hclk) disable iff (!hresetn)
    (ce && !run_en_ff[1]) |=> !timer1_irq;
  endproperty
  a_noirq1: assert property (p_noirq1)
    else $error("disabled timer 1 raised interrupt");

  property p_cntwr;
    @(posedge hclk) disable iff (!hresetn)
    (ce && cnt0_wr) |=> (count0 == $past(cnt0_wdata));
  endproperty
  a_cntwr: assert property (p_cntwr)
    else $error("count write not loaded");

  property p_start;
    @(posedge hclk) disable iff (!hresetn)
    (ce && $rose(run_en_ff[1]) && !cnt1_wr) ##1 (ce && !cnt1_wr && run_en_ff[1])
      |=> (count1 == $past(reload1_ff));
  endproperty
  a_start: assert property (p_start)
    else $error("timer 1 did not load reload on start");

  property p_rd;
    @(posedge hclk) disable iff (!hresetn)
    (ce && addr_ok && !hwrite && addr_idx == `IDX_T0_COUNT_LO)
      |=> (hrdata[15:0] == $past(count0[15:0]) && hrdata[31:16] == 16'h0);
  endproperty
  a_rd: assert property (p_rd)
    else $error("count low read mismatch");

  property p_reload1;
    @(posedge hclk) disable iff (!hresetn)
    (ce && uf1 && !cnt1_wr && run_en_ff[1])
      |=> (count1 == $past(reload1_ff));
  endproperty
  a_reload1: assert property (p_reload1)
    else $error("timer 1 did not reload after underflow");

  property p_dec1;
    @(posedge hclk) disable iff (!hresetn)
    (ce && tick && run_en_ff[1] && !cnt1_wr && count1 != 32'h0 &&
      $past(run_en_ff[1]) && $past(run_en_ff[1], 2))
      |=> (count1 == $past(count1) - 32'h1);
  endproperty
  a_dec1: assert property (p_dec1)
    else $error("timer 1 failed to decrement on tick");

  property p_irq_src1;
    @(posedge hclk) disable iff (!hresetn)
    (timer1_irq && $past(ce))
      |-> $past(count1 == 32'h0 && run_en_ff[1] && tick);
  endproperty
  a_irq_src1: assert property (p_irq_src1)
    else $error("timer 1 interrupt without underflow");

  property p_hold0;
    @(posedge hclk) disable iff (!hresetn)
    (!run_en_ff[0] && !cnt0_wr) |=> (count0 == $past(count0));
  endproperty
  a_hold0: assert property (p_hold0)
    else $error("disabled timer 0 changed its count");

  property p_noirq0;
    @(posedge hclk) disable iff (!hresetn)
    (ce && !run_en_ff[0]) |=> !timer0_irq;
  endproperty
  a_noirq0: assert property (p_noirq0)
    else $error("disabled timer 0 raised interrupt");

  property p_cntwr1;
    @(posedge hclk) disable iff (!hresetn)
    (ce && cnt1_wr) |=> (count1 == $past(cnt1_wdata));
  endproperty
  a_cntwr1: assert property (p_cntwr1)
    else $error("timer 1 count write not loaded");

  // a low clock enable must freeze counters, prescale and requests
  property p_freeze;
    @(posedge hclk) disable iff (!hresetn)
    !ce |=> ($stable(count0) && $stable(count1) && $stable(timer0_irq) &&
      $stable(timer1_irq) && $stable(prescale_ff));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

  c_irq0: cover property (@(posedge hclk) disable iff (!hresetn) timer0_irq);
  c_irq1: cover property (@(posedge hclk) disable iff (!hresetn) timer1_irq);
  c_cntwr: cover property (@(posedge hclk) disable iff (!hresetn) cnt1_wr);
  c_oneshot: cover property (@(posedge hclk) disable iff (!hresetn)
    cnt0_wr && run_en_ff[0]);
  c_freeze: cover property (@(posedge hclk) disable iff (!hresetn)
    !ce && run_en_ff[0]);
endmodule

// ===== timer_consts.svh
/*
 register offsets, field positions and reset values for the dual
 reload down timer. assumes word-indexed offsets mapped to byte
 addresses four times the index.
*/
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define IDX_PRESCALER 16'hc030
`define IDX_RUN_EN 16'hc031
`define IDX_T0_RELOAD_LO 16'hc034
`define IDX_T0_RELOAD_HI 16'hc035
`define IDX_T0_COUNT_LO 16'hc036
`define IDX_T0_COUNT_HI 16'hc037
`define IDX_T1_RELOAD_LO 16'hc038
`define IDX_T1_RELOAD_HI 16'hc039
`define IDX_T1_COUNT_LO 16'hc03a
`define IDX_T1_COUNT_HI 16'hc03b

// ****************************************************************
// fields and reset values
// ****************************************************************
`define FIRST_TIMER_RUN_BIT 0
`define SECOND_TIMER_RUN_BIT 1
`define PRESCALE_RESET 8'h00
`define RUN_EN_RESET 2'h0
`define WORD_RESET 32'h0000_0000
`define HALF_LO_MSB 15
`define HALF_HI_LSB 16

`endif

// ===== timer_pkg.sv
/*
 types shared by the timer files.
 assumes nothing of its surroundings.
*/
package timer_pkg;
  typedef enum logic [1:0] {
    ch_idle,
    ch_load,
    ch_count
  } ch_state_t;
  typedef logic [31:0] word_t;
endpackage

// ===== tick_prescaler.sv
/*
 divides the master clock by prescale value plus one into a one-cycle
 tick pulse. assumes the divisor comes from a register on hclk.
*/
`timescale 1ns/1ns
`include "timer_consts.svh"
module tick_prescaler (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [7:0] tick_prescale_value,
  output logic tick
);
  logic [7:0] div_ff;

  // ****************************************************************
  // divider
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff <= `PRESCALE_RESET;
    end else if (ce) begin
      if (div_ff >= tick_prescale_value) begin
        div_ff <= 8'h00;
      end else begin
        div_ff <= div_ff + 8'h01;
      end
    end
  end

  assign tick = ce && (div_ff >= tick_prescale_value);
endmodule

// ===== timer_channel.sv
/*
 one 32-bit down counter with reload and one-shot count load.
 assumes a one-cycle tick and register writes on hclk.
*/
`timescale 1ns/1ns
`include "timer_consts.svh"
module timer_channel (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic run,
  input wire logic tick,
  input wire logic [31:0] reload,
  input wire logic count_wr,
  input wire logic [31:0] count_wdata,
  output logic [31:0] count,
  output logic underflow
);
  timer_pkg::ch_state_t state_ff;
  logic [31:0] count_ff;

  // ****************************************************************
  // control and count
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= timer_pkg::ch_idle;
      count_ff <= `WORD_RESET;
    end else if (ce) begin
      if (count_wr) begin
        count_ff <= count_wdata;
      end
      case (state_ff)
        timer_pkg::ch_idle: begin
          if (run) begin
            state_ff <= timer_pkg::ch_load;
          end
        end
        timer_pkg::ch_load: begin
          if (!run) begin
            state_ff <= timer_pkg::ch_idle;
          end else begin
            if (!count_wr) begin
              count_ff <= reload;
            end
            state_ff <= timer_pkg::ch_count;
          end
        end
        timer_pkg::ch_count: begin
          if (!run) begin
            state_ff <= timer_pkg::ch_idle;
          end else if (tick && !count_wr) begin
            if (count_ff == 32'h0000_0000) begin
              count_ff <= reload;
            end else begin
              count_ff <= count_ff - 32'h0000_0001;
            end
          end
        end
        default: begin
          state_ff <= timer_pkg::ch_idle;
        end
      endcase
    end
  end

  assign count = count_ff;
  assign underflow = ce && run && !count_wr && tick &&
    (state_ff == timer_pkg::ch_count) &&
    (count_ff == 32'h0000_0000);
endmodule

// ===== tb.sv
/*
 self-checking bench for the dual reload down timer: register rows,
 tick periods, live count, one-shot load and a mid-run reset.
 assumes the design files and timer_consts.svh on the include path.
*/
`timescale 1ns/1ns
`include "timer_consts.svh"
module tb;
  // ************
  // design
  // ************
  typedef struct {
    logic [15:0] idx;
    logic [31:0] wd;
    logic [31:0] exp;
  } row_t;
  typedef struct {
    int sel;
    logic [7:0] pre;
    logic [15:0] rel;
    int exp;
  } per_t;
  logic hclk;
  logic hresetn;
  logic ce;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic timer0_irq;
  logic timer1_irq;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int other_hits = 0;
  row_t rows[11] = '{
    '{`IDX_PRESCALER, 32'h0000_01a5, 32'h0000_00a5},
    '{`IDX_RUN_EN, 32'h0000_fffc, 32'h0000_0000},
    '{`IDX_T0_RELOAD_LO, 32'habcd_1234, 32'h0000_1234},
    '{`IDX_T0_RELOAD_HI, 32'h1234_5678, 32'h0000_5678},
    '{`IDX_T0_COUNT_LO, 32'h0000_beef, 32'h0000_beef},
    '{`IDX_T0_COUNT_HI, 32'h0000_0042, 32'h0000_0042},
    '{`IDX_T1_RELOAD_LO, 32'h0000_0011, 32'h0000_0011},
    '{`IDX_T1_RELOAD_HI, 32'h0000_0022, 32'h0000_0022},
    '{`IDX_T1_COUNT_LO, 32'h0000_3333, 32'h0000_3333},
    '{`IDX_T1_COUNT_HI, 32'h0000_4444, 32'h0000_4444},
    '{16'hc032, 32'hffff_ffff, 32'h0000_0000}};
  // reload 0 and prescale 255 are the boundary cases
  per_t periods[5] = '{'{0, 8'h00, 16'h0003, 4}, '{1, 8'h02, 16'h0004, 15},
    '{0, 8'h01, 16'h0000, 2}, '{1, 8'h00, 16'h0000, 1},
    '{0, 8'hff, 16'h0001, 512}};

  dual_reload_down_timer dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .timer0_irq(timer0_irq), .timer1_irq(timer1_irq));

  // ************
  // checks and bus
  // ************
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check_word(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_cycles(input string what, input int exp,
                              input int got);
    compares++;
    if (got != exp) begin
      mismatches++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic check_true(input string what, input logic got);
    compares++;
    if (got !== 1'b1) begin
      mismatches++;
      $display("mismatch %s expected 1 seen %b", what, got);
    end
  endtask
  // no wait limit here: only the cycle ceiling ends a stuck transfer
  task automatic bus(input logic wr, input logic [15:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {14'h0000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr_reg(input logic [15:0] idx, input logic [31:0] wd);
    logic [31:0] unused;
    bus(1'b1, idx, wd, unused);
  endtask
  task automatic rd_reg(input logic [15:0] idx, output logic [31:0] v);
    bus(1'b0, idx, 32'h0000_0000, v);
  endtask
  // irq is a one-cycle pulse, so it is sampled at the falling edge
  task automatic wait_irq(input int sel, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit) begin
      @(negedge hclk);
      n++;
      hit = (sel == 0) ? (timer0_irq === 1'b1) : (timer1_irq === 1'b1);
      if (((sel == 0) ? timer1_irq : timer0_irq) === 1'b1) begin
        other_hits++;
      end
    end
  endtask
  task automatic quiet(input int cyc, output int hits);
    hits = 0;
    repeat (cyc) begin
      @(negedge hclk);
      if (timer0_irq === 1'b1 || timer1_irq === 1'b1) begin
        hits++;
      end
    end
  endtask

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      $display("timeout after %0d cycles", cycles);
      finish_test();
    end
  end

  // ************
  // tests
  // ************
  initial begin
    logic [31:0] v;
    logic [31:0] v2;
    logic [15:0] base;
    int n;
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      rd_reg(rows[i].idx, v);
      check_word("reset value", 32'h0000_0000, v);
    end
    foreach (rows[i]) begin
      wr_reg(rows[i].idx, rows[i].wd);
      rd_reg(rows[i].idx, v);
      check_word("register", rows[i].exp, v);
    end
    $display("test registers done");
    foreach (periods[i]) begin
      wr_reg(`IDX_RUN_EN, 32'h0000_0000);
      wr_reg(`IDX_PRESCALER, {24'h000000, periods[i].pre});
      base = periods[i].sel ? `IDX_T1_RELOAD_LO : `IDX_T0_RELOAD_LO;
      wr_reg(base, {16'h0000, periods[i].rel});
      wr_reg(base + 16'h0001, 32'h0000_0000);
      other_hits = 0;
      wr_reg(`IDX_RUN_EN, 32'h0000_0001 << periods[i].sel);
      wait_irq(periods[i].sel, n);
      wait_irq(periods[i].sel, n);
      check_cycles("irq period", periods[i].exp, n);
      check_cycles("other irq", 0, other_hits);
    end
    $display("test periods done");
    wr_reg(`IDX_RUN_EN, 32'h0000_0000);
    wr_reg(`IDX_PRESCALER, 32'h0000_0000);
    wr_reg(`IDX_T0_RELOAD_LO, 32'h0000_0003);
    wr_reg(`IDX_T0_RELOAD_HI, 32'h0000_0002);
    wr_reg(`IDX_RUN_EN, 32'h0000_0001);
    repeat (20) @(posedge hclk);
    wr_reg(`IDX_RUN_EN, 32'h0000_0000);
    rd_reg(`IDX_T0_COUNT_HI, v);
    check_word("count high", 32'h0000_0001, v);
    rd_reg(`IDX_T0_COUNT_LO, v);
    check_true("count low", v[31:8] == 24'h0000ff);
    quiet(100, n);
    rd_reg(`IDX_T0_COUNT_LO, v2);
    check_word("held count", v, v2);
    check_cycles("irq while off", 0, n);
    $display("test live count done");
    wr_reg(`IDX_T0_RELOAD_LO, 32'h0000_0040);
    wr_reg(`IDX_T0_RELOAD_HI, 32'h0000_0000);
    wr_reg(`IDX_RUN_EN, 32'h0000_0001);
    wr_reg(`IDX_T0_COUNT_LO, 32'h0000_0005);
    wait_irq(0, n);
    check_true("one-shot delay", n >= 5 && n < 12);
    wait_irq(0, n);
    check_cycles("period after one-shot", 65, n);
    // 50 frozen cycles must push the next request out by exactly 50
    @(posedge hclk);
    ce <= 1'b0;
    quiet(50, n);
    check_cycles("irq while frozen", 0, n);
    @(posedge hclk);
    ce <= 1'b1;
    wait_irq(0, n);
    check_cycles("period across freeze", 65, n);
    $display("test one-shot done");
    wr_reg(`IDX_T1_RELOAD_LO, 32'h0000_0002);
    wr_reg(`IDX_T1_RELOAD_HI, 32'h0000_0000);
    wr_reg(`IDX_RUN_EN, 32'h0000_0003);
    wait_irq(1, n);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(negedge hclk);
    check_word("irq reset", 32'h0, {30'h0, timer1_irq, timer0_irq});
    check_word("bus in reset", 32'h2, {30'h0, hreadyout, hresp});
    @(posedge hclk);
    hresetn <= 1'b1;
    rd_reg(`IDX_RUN_EN, v);
    check_word("enables after reset", 32'h0000_0000, v);
    rd_reg(`IDX_T1_RELOAD_LO, v);
    check_word("reload after reset", 32'h0000_0000, v);
    quiet(100, n);
    check_cycles("irq after reset", 0, n);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
